/* File: logic/timer_pkg.sv */
/*
 * constants, register map and types of the channel 1/2 timer counter.
 * assumes a 12-bit cpu data address space and an 8-bit register data path.
 */
package timer_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CH2_MODE_ADDR     = 12'h0f90;
  localparam logic [11:0] CH1_MODE_ADDR     = 12'h0fa8;
  localparam logic [11:0] CH2_CTRL_ADDR     = 12'h0f92;
  localparam logic [11:0] LOW_MOD_ADDR      = 12'h0f94;
  localparam logic [11:0] HIGH_MOD_ADDR     = 12'h0f96;
  localparam logic [11:0] CH1_MOD_ADDR      = 12'h0faa;
  localparam logic [11:0] CH2_COUNT_ADDR    = 12'h0f98;
  localparam logic [11:0] CH1_COUNT_ADDR    = 12'h0fac;
  localparam logic [11:0] FLAG_ADDR         = 12'h0f9a;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned START_BIT         = 3;
  localparam int unsigned RUN_BIT           = 2;
  localparam int unsigned MODE_LSB          = 0;
  localparam int unsigned PSEL_LSB          = 4;
  localparam int unsigned OE2_BIT           = 3;
  localparam logic [7:0]  MODE_RST          = 8'h00;
  localparam logic [7:0]  CTRL_RST          = 8'h00;
  localparam logic [7:0]  MOD_RST           = 8'h00;

  // ----------------------------------------------------------------
  // mode codes and count pulse codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_8BIT         = 2'b00;
  localparam logic [1:0]  MODE_PWM          = 2'b01;
  localparam logic [1:0]  MODE_CASC         = 2'b10;
  localparam logic [2:0]  PSEL_A            = 3'b010;
  localparam logic [2:0]  PSEL_B            = 3'b011;
  localparam logic [2:0]  PSEL_C            = 3'b100;
  localparam logic [2:0]  PSEL_D            = 3'b101;
  localparam logic [2:0]  PSEL_E            = 3'b110;
  localparam logic [2:0]  PSEL_F            = 3'b111;

  // divider exponents of fx per pulse code
  localparam int unsigned CH2_EXP_A         = 1;
  localparam int unsigned CH2_EXP_B         = 0;
  localparam int unsigned CH2_EXP_C         = 10;
  localparam int unsigned CH2_EXP_D         = 8;
  localparam int unsigned CH2_EXP_E         = 6;
  localparam int unsigned CH2_EXP_F         = 4;
  localparam int unsigned CH1_EXP_B         = 5;
  localparam int unsigned CH1_EXP_C         = 12;
  localparam int unsigned CH1_EXP_D         = 10;
  localparam int unsigned CH1_EXP_E         = 8;
  localparam int unsigned CH1_EXP_F         = 6;
  localparam int unsigned PRESCALE_BITS     = 12;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WR_BYTE   = 2'b00,
    WR_NIBBLE = 2'b01,
    WR_BIT    = 2'b10
  } wsize_t;

  typedef enum logic [1:0] {
    PH_HIGH = 2'b01,
    PH_LOW  = 2'b10
  } phase_t;

endpackage

/* File: logic/prescale_if.sv */
/*
 * carrier for the divided count pulse ticks.
 * assumes tick[k] is a one-cycle pulse every 2**k clocks, tick[0] always high.
 */
`timescale 1ns/1ps
interface prescale_if;
  logic [timer_pkg::PRESCALE_BITS:0] tick;
  modport src (output tick);
  modport dst (input  tick);
endinterface

/* File: logic/timer_prescaler.sv */
/*
 * free-running divider of the system clock fx into power-of-two ticks.
 * assumes one clock domain; tick outputs are decoded from the counter.
 */
`timescale 1ns/1ps
module timer_prescaler
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // ticks
  prescale_if.src   pre
);

  logic [PRESCALE_BITS-1:0] div_r;
  logic [PRESCALE_BITS-1:0] div_nxt;

  always_comb begin
    div_nxt = div_r + 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign pre.tick[0] = 1'b1;

  genvar k;
  generate
    for (k = 1; k <= PRESCALE_BITS; k++) begin : g_tick
      assign pre.tick[k] = &div_r[k-1:0];
    end
  endgenerate

endmodule

/* File: logic/timer_pwm_and_cascade.sv */
/*
 * timer counter channels 1 and 2: 8-bit, pwm and 16-bit cascade modes.
 * assumes a cpu register port on clk_i with byte, nibble and bit writes,
 * and a port pin outside that already routes timer_out_pin_o.
 */
// Operation
// - pwm: high-period match toggles output and selects low-period compare
// - pwm: low-period match sets flag, toggles, returns to high compare
// - pwm phases alternate forever while counting runs
// - output enable 0 holds pin low, 1 drives toggle flip-flop
// - start bit writable alone, self-clears; rest of mode written bytewise
// - both mode registers reset to zero
// - control register resets to zero; byte, nibble and bit writes
// - writing start clears counter and flag; counting follows if run set
// - run bit 0 holds count, 1 lets it count
// - cascade mode when channel 2 and channel 1 mode bits are 10, 10
// - channel 2 pulse codes select fx/2, fx, fx/1024, fx/256, fx/64, fx/16
// - channel 1 codes: ch2 overflow, fx/32, fx/4096, /1024, /256, /64
// - cascade joins both channels into one 16-bit interval timer
// - period is modulo value plus one count pulses
// - pwm is channel 2 mode 01, whatever the channel 1 mode bits
// - cascade feeds channel 2 overflow into channel 1 count input
// - cascade flag and toggle only when both counters match together
`timescale 1ns/1ps
module timer_pwm_and_cascade
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // cpu register port
  input  wire logic [11:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire timer_pkg::wsize_t reg_wsize_i,
  input  wire logic [2:0]  reg_bit_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  // interrupt flags and acknowledge
  input  wire logic        irq2_clr_i,
  input  wire logic        irq1_clr_i,
  output logic             ch2_irq_flag_o,
  output logic             ch1_irq_flag_o,
  // timer output pin
  output logic             timer_out_pin_o
);
  import timer_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] channel2_mode_reg_r, channel2_mode_reg_nxt;
  logic [7:0] channel1_mode_reg_r, channel1_mode_reg_nxt;
  logic [7:0] channel2_control_reg_r, channel2_control_reg_nxt;
  logic [7:0] low_period_modulo_r, low_period_modulo_nxt;
  logic [7:0] high_period_modulo_r, high_period_modulo_nxt;
  logic [7:0] channel1_modulo_r, channel1_modulo_nxt;
  logic [7:0] channel2_counter_r, channel2_counter_nxt;
  logic [7:0] channel1_counter_r, channel1_counter_nxt;
  logic       ch2_irq_flag_r, ch2_irq_flag_nxt;
  logic       chan_irq_flag_r, chan_irq_flag_nxt;
  logic       output_toggle_ff_r, output_toggle_ff_nxt;
  phase_t     phase_r, phase_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  prescale_if pre ();

  timer_prescaler u_pre (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pre   (pre)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic       wr_tm2, wr_tm1, start2_w, start1_w, start2, start1;
  logic       pwm_mode, casc_mode, run2, run1, cp2, cp1sel, cp1;
  logic       step2, match2, match1, full, event2, ovf2, step1;
  logic [7:0] tgt2;

  // pulse select; unlisted codes give no pulse
  function automatic logic ch2_pulse(input logic [2:0] code,
                                     input logic [PRESCALE_BITS:0] t);
    case (code)
      PSEL_A:  ch2_pulse = t[CH2_EXP_A];
      PSEL_B:  ch2_pulse = t[CH2_EXP_B];
      PSEL_C:  ch2_pulse = t[CH2_EXP_C];
      PSEL_D:  ch2_pulse = t[CH2_EXP_D];
      PSEL_E:  ch2_pulse = t[CH2_EXP_E];
      PSEL_F:  ch2_pulse = t[CH2_EXP_F];
      default: ch2_pulse = 1'b0;
    endcase
  endfunction

  function automatic logic ch1_pulse(input logic [2:0] code,
                                     input logic [PRESCALE_BITS:0] t,
                                     input logic ovf);
    case (code)
      PSEL_A:  ch1_pulse = ovf;
      PSEL_B:  ch1_pulse = t[CH1_EXP_B];
      PSEL_C:  ch1_pulse = t[CH1_EXP_C];
      PSEL_D:  ch1_pulse = t[CH1_EXP_D];
      PSEL_E:  ch1_pulse = t[CH1_EXP_E];
      PSEL_F:  ch1_pulse = t[CH1_EXP_F];
      default: ch1_pulse = 1'b0;
    endcase
  endfunction

  always_comb begin
    wr_tm2    = reg_wr_i && (reg_addr_i == CH2_MODE_ADDR);
    wr_tm1    = reg_wr_i && (reg_addr_i == CH1_MODE_ADDR);
    // a bit write only reaches the start bit; a byte write may carry it too
    start2_w  = wr_tm2 && reg_wdata_i[START_BIT] && (reg_wsize_i == WR_BYTE) ||
                wr_tm2 && (reg_wsize_i == WR_BIT) && (reg_bit_i == 3'(START_BIT))
                       && reg_wdata_i[0];
    start1_w  = wr_tm1 && reg_wdata_i[START_BIT] && (reg_wsize_i == WR_BYTE) ||
                wr_tm1 && (reg_wsize_i == WR_BIT) && (reg_bit_i == 3'(START_BIT))
                       && reg_wdata_i[0];
    pwm_mode  = channel2_mode_reg_r[MODE_LSB +: 2] == MODE_PWM;
    casc_mode = (channel2_mode_reg_r[MODE_LSB +: 2] == MODE_CASC) &&
                (channel1_mode_reg_r[MODE_LSB +: 2] == MODE_CASC);
    start2    = start2_w;
    start1    = start1_w || (casc_mode && start2_w);
    run2      = channel2_mode_reg_r[RUN_BIT];
    run1      = casc_mode ? run2 : channel1_mode_reg_r[RUN_BIT];
    cp2       = ch2_pulse(channel2_mode_reg_r[PSEL_LSB +: 3], pre.tick);
    tgt2      = (pwm_mode && (phase_r == PH_HIGH)) ? high_period_modulo_r
                                                   : low_period_modulo_r;
    step2     = run2 && cp2 && !start2;
    match2    = channel2_counter_r == tgt2;
    match1    = channel1_counter_r == channel1_modulo_r;
    full      = casc_mode ? (match2 && match1) : match2;
    event2    = step2 && full;
    ovf2      = step2 && (channel2_counter_r == 8'hff) && !(casc_mode && full);
    cp1sel    = ch1_pulse(channel1_mode_reg_r[PSEL_LSB +: 3], pre.tick, ovf2);
    cp1       = casc_mode ? ovf2 : cp1sel;
    step1     = run1 && cp1 && !start1 && !casc_mode;
  end

  // ----------------------------------------------------------------
  // registers written by the cpu
  // ----------------------------------------------------------------
  always_comb begin
    channel2_mode_reg_nxt    = channel2_mode_reg_r;
    channel1_mode_reg_nxt    = channel1_mode_reg_r;
    channel2_control_reg_nxt = channel2_control_reg_r;
    low_period_modulo_nxt    = low_period_modulo_r;
    high_period_modulo_nxt   = high_period_modulo_r;
    channel1_modulo_nxt      = channel1_modulo_r;
    // start bit reads back one cycle, then clears as the timer starts
    channel2_mode_reg_nxt[START_BIT] = 1'b0;
    channel1_mode_reg_nxt[START_BIT] = 1'b0;
    if (wr_tm2) begin
      if (reg_wsize_i == WR_BYTE) begin
        channel2_mode_reg_nxt = {1'b0, reg_wdata_i[6:0]};
      end else if (start2_w) begin
        channel2_mode_reg_nxt[START_BIT] = 1'b1;
      end
    end
    if (wr_tm1) begin
      if (reg_wsize_i == WR_BYTE) begin
        channel1_mode_reg_nxt = {1'b0, reg_wdata_i[6:0]};
      end else if (start1_w) begin
        channel1_mode_reg_nxt[START_BIT] = 1'b1;
      end
    end
    if (reg_wr_i && (reg_addr_i == CH2_CTRL_ADDR)) begin
      case (reg_wsize_i)
        WR_BYTE:   channel2_control_reg_nxt = reg_wdata_i;
        WR_NIBBLE: begin
          if (reg_bit_i[2]) begin
            channel2_control_reg_nxt[7:4] = reg_wdata_i[3:0];
          end else begin
            channel2_control_reg_nxt[3:0] = reg_wdata_i[3:0];
          end
        end
        WR_BIT:    channel2_control_reg_nxt[reg_bit_i] = reg_wdata_i[0];
        default:   channel2_control_reg_nxt = channel2_control_reg_r;
      endcase
    end
    if (reg_wr_i && (reg_wsize_i == WR_BYTE)) begin
      if (reg_addr_i == LOW_MOD_ADDR)  low_period_modulo_nxt  = reg_wdata_i;
      if (reg_addr_i == HIGH_MOD_ADDR) high_period_modulo_nxt = reg_wdata_i;
      if (reg_addr_i == CH1_MOD_ADDR)  channel1_modulo_nxt    = reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // counters, phase, flags and output flip-flop
  // ----------------------------------------------------------------
  always_comb begin
    channel2_counter_nxt = channel2_counter_r;
    channel1_counter_nxt = channel1_counter_r;
    phase_nxt            = phase_r;
    output_toggle_ff_nxt = output_toggle_ff_r;
    ch2_irq_flag_nxt     = ch2_irq_flag_r && !irq2_clr_i;
    chan_irq_flag_nxt    = chan_irq_flag_r && !irq1_clr_i;
    if (start2) begin
      channel2_counter_nxt = 8'h00;
      ch2_irq_flag_nxt     = 1'b0;
      phase_nxt            = PH_HIGH;
    end else if (step2) begin
      // modulo n gives n+1 pulses per interval
      channel2_counter_nxt = full ? 8'h00 : channel2_counter_r + 8'h01;
    end
    if (event2) begin
      output_toggle_ff_nxt = !output_toggle_ff_r;
      if (pwm_mode) begin
        case (phase_r)
          PH_HIGH: phase_nxt = PH_LOW;
          PH_LOW: begin
            phase_nxt        = PH_HIGH;
            ch2_irq_flag_nxt = 1'b1;
          end
          default: phase_nxt = PH_HIGH;
        endcase
      end else begin
        ch2_irq_flag_nxt = 1'b1;
      end
    end
    if (start1) begin
      channel1_counter_nxt = 8'h00;
      chan_irq_flag_nxt    = 1'b0;
    end else if (casc_mode) begin
      if (event2) begin
        channel1_counter_nxt = 8'h00;
      end else if (ovf2) begin
        channel1_counter_nxt = channel1_counter_r + 8'h01;
      end
    end else if (step1) begin
      channel1_counter_nxt = match1 ? 8'h00 : channel1_counter_r + 8'h01;
      if (match1) begin
        chan_irq_flag_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd_i) begin
      case (reg_addr_i)
        CH2_MODE_ADDR:  rdata_nxt = channel2_mode_reg_r;
        CH1_MODE_ADDR:  rdata_nxt = channel1_mode_reg_r;
        CH2_CTRL_ADDR:  rdata_nxt = channel2_control_reg_r;
        LOW_MOD_ADDR:   rdata_nxt = low_period_modulo_r;
        HIGH_MOD_ADDR:  rdata_nxt = high_period_modulo_r;
        CH1_MOD_ADDR:   rdata_nxt = channel1_modulo_r;
        CH2_COUNT_ADDR: rdata_nxt = channel2_counter_r;
        CH1_COUNT_ADDR: rdata_nxt = channel1_counter_r;
        FLAG_ADDR:      rdata_nxt = {6'h00, chan_irq_flag_r, ch2_irq_flag_r};
        default:        rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      channel2_mode_reg_r    <= MODE_RST;
      channel1_mode_reg_r    <= MODE_RST;
      channel2_control_reg_r <= CTRL_RST;
      low_period_modulo_r    <= MOD_RST;
      high_period_modulo_r   <= MOD_RST;
      channel1_modulo_r      <= MOD_RST;
      channel2_counter_r     <= 8'h00;
      channel1_counter_r     <= 8'h00;
      ch2_irq_flag_r         <= 1'b0;
      chan_irq_flag_r        <= 1'b0;
      output_toggle_ff_r     <= 1'b0;
      phase_r                <= PH_HIGH;
      rdata_r                <= 8'h00;
    end else begin
      channel2_mode_reg_r    <= channel2_mode_reg_nxt;
      channel1_mode_reg_r    <= channel1_mode_reg_nxt;
      channel2_control_reg_r <= channel2_control_reg_nxt;
      low_period_modulo_r    <= low_period_modulo_nxt;
      high_period_modulo_r   <= high_period_modulo_nxt;
      channel1_modulo_r      <= channel1_modulo_nxt;
      channel2_counter_r     <= channel2_counter_nxt;
      channel1_counter_r     <= channel1_counter_nxt;
      ch2_irq_flag_r         <= ch2_irq_flag_nxt;
      chan_irq_flag_r        <= chan_irq_flag_nxt;
      output_toggle_ff_r     <= output_toggle_ff_nxt;
      phase_r                <= phase_nxt;
      rdata_r                <= rdata_nxt;
    end
  end

  // pin is gated, not registered, so enable takes effect at once
  assign timer_out_pin_o = channel2_control_reg_r[OE2_BIT] && output_toggle_ff_r;
  assign ch2_irq_flag_o  = ch2_irq_flag_r;
  assign ch1_irq_flag_o  = chan_irq_flag_r;
  assign reg_rdata_o     = rdata_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_high_hit;
    pwm_mode && (phase_r == PH_HIGH) && event2;
  endsequence

  sequence s_low_hit;
    pwm_mode && (phase_r == PH_LOW) && event2;
  endsequence

  property p_pwm_high;
    @(posedge clk_i) disable iff (rst_i)
    s_high_hit |=> (phase_r == PH_LOW) && (output_toggle_ff_r != $past(output_toggle_ff_r))
                   && (channel2_counter_r == 8'h00);
  endproperty
  a_pwm_high: assert property (p_pwm_high) else $error("high match misbehaved");

  property p_pwm_no_flag;
    @(posedge clk_i) disable iff (rst_i)
    s_high_hit and !ch2_irq_flag_r |=> !ch2_irq_flag_r;
  endproperty
  a_pwm_no_flag: assert property (p_pwm_no_flag) else $error("high match set flag");

  property p_pwm_low;
    @(posedge clk_i) disable iff (rst_i)
    s_low_hit |=> ch2_irq_flag_r && (phase_r == PH_HIGH)
                  && (output_toggle_ff_r != $past(output_toggle_ff_r));
  endproperty
  a_pwm_low: assert property (p_pwm_low) else $error("low match misbehaved");

  property p_pin;
    @(posedge clk_i) disable iff (rst_i)
    timer_out_pin_o == (channel2_control_reg_r[OE2_BIT] && output_toggle_ff_r);
  endproperty
  a_pin: assert property (p_pin) else $error("pin not gated by enable");

  sequence s_start2;
    start2_w;
  endsequence

  property p_start_self_clear;
    @(posedge clk_i) disable iff (rst_i)
    // a second start one cycle later legally keeps the bit up
    s_start2 |=> channel2_mode_reg_r[START_BIT]
                 ##1 (!channel2_mode_reg_r[START_BIT] || $past(start2_w));
  endproperty
  a_start_self_clear: assert property (p_start_self_clear) else $error("start bit stuck");

  property p_start_clears;
    @(posedge clk_i) disable iff (rst_i)
    s_start2 and !irq2_clr_i |=> (channel2_counter_r == 8'h00) && !ch2_irq_flag_r;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start did not clear");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    !run2 && !start2 |=> $stable(channel2_counter_r);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped counter moved");

  property p_casc_carry;
    @(posedge clk_i) disable iff (rst_i)
    casc_mode && ovf2 && !start1 |=> channel1_counter_r == $past(channel1_counter_r) + 8'h01;
  endproperty
  a_casc_carry: assert property (p_casc_carry) else $error("carry lost");

  property p_casc_full;
    @(posedge clk_i) disable iff (rst_i)
    casc_mode && step2 && match2 && !match1 && !ch2_irq_flag_r |=> !ch2_irq_flag_r;
  endproperty
  a_casc_full: assert property (p_casc_full) else $error("half match set flag");

endmodule

/* File: bench/tb_top.sv */
/*
 * self-checking bench for the channel 1/2 timer: registers, pwm, cascade.
 * assumes the design package timer_pkg and a 100 MHz clk_i.
 */
`timescale 1ns/1ps
module tb_top;
  import timer_pkg::*;
  logic clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, irq2_clr_i = 0, irq1_clr_i = 0;
  logic [11:0] reg_addr_i = 12'h0000;
  wsize_t      reg_wsize_i = WR_BYTE;
  logic [2:0]  reg_bit_i = 3'h0;
  logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o, d;
  logic        ch2_irq_flag_o, ch1_irq_flag_o, timer_out_pin_o;
  int          err_total = 0, n_tests = 0, n;
  timer_pwm_and_cascade dut_u (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wsize_i(reg_wsize_i), .reg_bit_i(reg_bit_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .irq2_clr_i(irq2_clr_i), .irq1_clr_i(irq1_clr_i), .ch2_irq_flag_o(ch2_irq_flag_o),
    .ch1_irq_flag_o(ch1_irq_flag_o), .timer_out_pin_o(timer_out_pin_o));
  initial forever #5 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v, input wsize_t s, input int b);
    @(posedge clk_i);
    reg_wr_i <= 1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wsize_i <= s;
    reg_bit_i <= b[2:0];
    @(posedge clk_i);
    reg_wr_i <= 0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk_i);
    reg_rd_i <= 1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 0;
    #1 v = reg_rdata_o;
  endtask
  // bounded wait for the ch2 flag, edges counted in c
  task automatic wait_flag(output int c);
    c = 0;
    while (ch2_irq_flag_o !== 1'b1) begin
      if (c > 9000) begin
        err_total++;
        end_of_test();
      end
      @(posedge clk_i);
      #1 c++;
    end
  endtask
  // waits for the flag, clears it, then counts clocks from that set to the next set
  task automatic period(output int p);
    // let a start strobe on this edge clear the old flag first
    #1 wait_flag(p);
    @(posedge clk_i);
    irq2_clr_i <= 1;
    @(posedge clk_i);
    irq2_clr_i <= 0;
    #1 wait_flag(p);
    p = p + 2;
  endtask
  task automatic pin_high(output int h);
    h = 0;
    repeat (70) begin
      @(posedge clk_i);
      #1 h += (timer_out_pin_o === 1'b1);
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(CH2_MODE_ADDR, d); chk(d, 8'h00);
    rd(CH1_MODE_ADDR, d); chk(d, 8'h00);
    rd(CH2_CTRL_ADDR, d); chk(d, 8'h00);
    rd(12'h0000, d); chk(d, 8'h00);
  endtask
  task automatic t_pwm();
    int e[6] = '{1, 0, 10, 8, 6, 4};
    int h;
    wr(HIGH_MOD_ADDR, 8'h02, WR_BYTE, 0);
    wr(LOW_MOD_ADDR, 8'h03, WR_BYTE, 0);
    // each code: 3 + 4 pulses per pwm cycle, one flag per cycle
    for (int i = 0; i < 6; i++) begin
      wr(CH2_MODE_ADDR, {1'b0, 3'(i + 2), 4'hd}, WR_BYTE, 0);
      period(n);
      chk(n, 7 << e[i]);
    end
    wr(CH2_MODE_ADDR, 8'h3d, WR_BYTE, 0);
    rd(CH2_MODE_ADDR, d); chk(d, 8'h35);
    pin_high(h); chk(h, 0);
    wr(CH2_CTRL_ADDR, 8'h01, WR_BIT, OE2_BIT);
    rd(CH2_CTRL_ADDR, d); chk(d, 8'h08);
    pin_high(h); chk(h == 40 || h == 30, 1);
  endtask
  task automatic t_casc();
    logic [7:0] c0;
    wr(CH1_MOD_ADDR, 8'h01, WR_BYTE, 0);
    wr(LOW_MOD_ADDR, 8'h03, WR_BYTE, 0);
    wr(CH1_MODE_ADDR, 8'h22, WR_BYTE, 0);
    wr(CH2_MODE_ADDR, 8'h3e, WR_BYTE, 0);
    period(n); chk(n, 260);
    period(n); chk(n, 260);
    wait_flag(n);
    rd(FLAG_ADDR, d); chk(d, 8'h01);
    chk(ch1_irq_flag_o, 0);
    wr(CH2_MODE_ADDR, 8'h01, WR_BIT, START_BIT);
    #1 chk(ch2_irq_flag_o, 0);
    period(n); chk(n, 260);
    wr(CH2_MODE_ADDR, 8'h32, WR_BYTE, 0);
    // the last period left the flag up; clear it so a stopped timer must keep it low
    @(posedge clk_i);
    irq2_clr_i <= 1;
    @(posedge clk_i);
    irq2_clr_i <= 0;
    rd(CH2_COUNT_ADDR, c0);
    repeat (20) @(posedge clk_i);
    rd(CH2_COUNT_ADDR, d); chk(d, c0);
    chk(ch2_irq_flag_o, 0);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    t_reset();
    t_pwm();
    wr(CH2_CTRL_ADDR, 8'h00, WR_BYTE, 0);
    wr(CH2_MODE_ADDR, 8'h00, WR_BYTE, 0);
    t_casc();
    end_of_test();
  end
endmodule
